// [src/cpc_codec_power_ctrl.v]
// Operation
// - After reset both digital filters run at 64x oversampling.
// - dac_control bit 3 picks DAC oversampling, 0 is 64x, 1 is 128x.
// - adc_control bit 3 picks ADC oversampling, 0 is 64x, 1 is 128x.
// - Midrail field bits 1:0: off, 50k, 500k, 5k impedance.
// - Midrail field 00 means all analogue circuitry is non-operational.
// - power_control_one bit 3 enables analogue bias; resets to 0.
// - dac_control bit 6 set soft-mutes the DAC path.
// - Any reset returns every register to its default.
// - Any write to address zero restores every register default.
`timescale 1ns/100ps
`include "cpc_codec_map.vh"

module cpc_codec_power_ctrl #(
  parameter ADDR_W = `CPC_ADDR_W,
  parameter WORD_W = `CPC_WORD_W
) (
  input wire sys_clk, // 50 MHz system clock
  input wire reset, // Synchronous power-on reset, high
  input wire ctrlClk, // Serial control clock pin
  input wire ctrlData, // Serial control data pin
  input wire ctrlLatch, // Serial word latch pin, low during a word
  input wire [ADDR_W-1:0] regReadAddr, // On-chip read address
  output wire [WORD_W-1:0] regReadData_q, // Registered read data
  output reg dacOversampleDouble_q, // DAC filter at 128x
  output reg adcOversampleDouble_q, // ADC filter at 128x
  output reg [7:0] dacRateSelect_q, // DAC oversampling ratio
  output reg [7:0] adcRateSelect_q, // ADC oversampling ratio
  output reg [1:0] midrailImpedanceSelect_q, // Reference string code
  output reg midrailReference_q, // Midrail reference running
  output reg analogOperational_q, // Analogue circuitry usable
  output reg analogBiasOn_q, // Analogue amplifier bias
  output reg dacSoftMute_q, // DAC path soft mute
  output reg [WORD_W-1:0] powerOneEnable_q, // Gated power_control_one
  output reg [WORD_W-1:0] powerTwoEnable_q, // Gated power_control_two
  output reg [WORD_W-1:0] powerThreeEnable_q, // Gated power_control_three
  output reg writeDone_q, // Pulse: a word was applied
  output reg softResetDone_q, // Pulse: address zero was written
  output reg frameError_q // Pulse: latch came with a wrong bit count
);

  localparam FRAME_W = 2 * 8;
  localparam CNT_W = 5;

  // One-hot frame states
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_SHIFT = 3'h2;
  localparam [2:0] ST_COMMIT = 3'h4;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Pins idle with the latch high and the serial clock low
  localparam [2:0] PIN_IDLE = 3'h4;

  wire [2:0] pinStable;
  wire clkLevel;
  wire dataLevel;
  wire latchLevel;

  // Stages carry no reset; hold reset with pins idle until they flush
  cpc_pin_sync #(
    .WIDTH(3)
  ) uSync (
    .sys_clk(sys_clk),
    .reset(reset),
    .pinIn({ctrlLatch, ctrlData, ctrlClk}),
    .resetLevel(PIN_IDLE),
    .pinStable(pinStable)
  );

  assign clkLevel = pinStable[0];
  assign dataLevel = pinStable[1];
  assign latchLevel = pinStable[2];

  reg clkPrev_q;
  reg latchPrev_q;
  wire clkRise;
  wire latchRise;
  wire latchFall;

  always @(posedge sys_clk) begin
    if (reset) begin
      clkPrev_q <= PIN_IDLE[0];
      latchPrev_q <= PIN_IDLE[2];
    end else begin
      clkPrev_q <= clkLevel;
      latchPrev_q <= latchLevel;
    end
  end

  assign clkRise = clkLevel & ~clkPrev_q;
  assign latchRise = latchLevel & ~latchPrev_q;
  assign latchFall = ~latchLevel & latchPrev_q;

  ////////////////////////////////////////////////////////////////////////
  // Serial word capture

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [FRAME_W-1:0] shift_q;
  reg [CNT_W-1:0] bitCount_q;
  reg [FRAME_W-1:0] word_q;
  wire frameComplete;

  // Exactly sixteen clock rises make a word; any other count is a framing fault
  assign frameComplete = (bitCount_q == `CPC_FRAME_BITS);

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (latchFall) begin
          state_d = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (latchRise) begin
          // Short or long words are dropped, never half-applied
          if (frameComplete) begin
            state_d = ST_COMMIT;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_COMMIT: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      shift_q <= {FRAME_W{1'b0}};
      bitCount_q <= {CNT_W{1'b0}};
      word_q <= {FRAME_W{1'b0}};
    end else begin
      state_q <= state_d;
      // Count restarts for every word so a dropped frame leaves nothing behind
      if (state_q == ST_IDLE) begin
        bitCount_q <= {CNT_W{1'b0}};
      end else if ((state_q == ST_SHIFT) && clkRise) begin
        // MSB first, so the address ends up in the top seven bits
        shift_q <= {shift_q[FRAME_W-2:0], dataLevel};
        // Saturate so an overlong word never wraps back to a legal count
        if (bitCount_q != {CNT_W{1'b1}}) begin
          bitCount_q <= bitCount_q + 5'h01;
        end
      end
      if ((state_q == ST_SHIFT) && latchRise) begin
        word_q <= shift_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write decode

  wire [ADDR_W-1:0] wordAddr;
  wire [WORD_W-1:0] wordData;
  wire committing;
  wire softResetHit;
  reg addrMapped;

  // Address sits above the nine data bits of the captured word
  assign wordAddr = word_q[FRAME_W-1:WORD_W];
  assign wordData = word_q[WORD_W-1:0];
  assign committing = (state_q == ST_COMMIT);
  assign softResetHit = committing && (wordAddr == `CPC_ADDR_SOFT_RESET);

  // Unlisted addresses other than zero are dropped without any pulse
  always @* begin
    case (wordAddr)
      `CPC_ADDR_POWER_ONE,
      `CPC_ADDR_POWER_TWO,
      `CPC_ADDR_POWER_THREE,
      `CPC_ADDR_AUDIO_PORT,
      `CPC_ADDR_COMPANDING,
      `CPC_ADDR_CLOCK_GEN,
      `CPC_ADDR_EXTRA,
      `CPC_ADDR_PIN_OUTPUT,
      `CPC_ADDR_DAC_CTRL,
      `CPC_ADDR_DAC_VOLUME,
      `CPC_ADDR_ADC_CTRL,
      `CPC_ADDR_ADC_VOLUME,
      `CPC_ADDR_LIMITER_ONE,
      `CPC_ADDR_LIMITER_TWO,
      `CPC_ADDR_NOTCH_ONE,
      `CPC_ADDR_NOTCH_TWO: begin
        addrMapped = 1'b1;
      end
      default: begin
        addrMapped = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Register store

  wire [`CPC_DEPTH*WORD_W-1:0] allWords;
  wire storeClear;
  wire storeWrite;

  // Address zero never lands in the store; its write only restores defaults
  assign storeClear = reset | softResetHit;
  assign storeWrite = committing & addrMapped;

  cpc_reg_store #(
    .ADDR_W(ADDR_W),
    .WORD_W(WORD_W),
    .DEPTH(`CPC_DEPTH)
  ) uStore (
    .sys_clk(sys_clk),
    .clear(storeClear),
    .wrEn(storeWrite),
    .wrAddr(wordAddr),
    .wrData(wordData),
    .rdAddr(regReadAddr),
    .rdData_q(regReadData_q),
    .allWords(allWords)
  );

  wire [WORD_W-1:0] powerOne;
  wire [WORD_W-1:0] powerTwo;
  wire [WORD_W-1:0] powerThree;
  wire [WORD_W-1:0] dacCtrl;
  wire [WORD_W-1:0] adcCtrl;

  assign powerOne = allWords[`CPC_ADDR_POWER_ONE*WORD_W +: WORD_W];
  assign powerTwo = allWords[`CPC_ADDR_POWER_TWO*WORD_W +: WORD_W];
  assign powerThree = allWords[`CPC_ADDR_POWER_THREE*WORD_W +: WORD_W];
  assign dacCtrl = allWords[`CPC_ADDR_DAC_CTRL*WORD_W +: WORD_W];
  assign adcCtrl = allWords[`CPC_ADDR_ADC_CTRL*WORD_W +: WORD_W];

  ////////////////////////////////////////////////////////////////////////
  // Control outputs

  wire [1:0] midrailCode;
  wire midrailOn;
  wire dacDouble;
  wire adcDouble;

  assign midrailCode = powerOne[`CPC_MIDRAIL_HI:`CPC_MIDRAIL_LO];
  assign midrailOn = (midrailCode != `CPC_MIDRAIL_OFF);
  assign dacDouble = dacCtrl[`CPC_BIT_OVERSAMPLE];
  assign adcDouble = adcCtrl[`CPC_BIT_OVERSAMPLE];

  // Outputs trail the store by one edge so every port is a flip-flop
  always @(posedge sys_clk) begin
    if (reset) begin
      dacOversampleDouble_q <= 1'b0;
      adcOversampleDouble_q <= 1'b0;
      dacRateSelect_q <= `CPC_OSR_LOW;
      adcRateSelect_q <= `CPC_OSR_LOW;
      midrailImpedanceSelect_q <= `CPC_MIDRAIL_OFF;
      midrailReference_q <= 1'b0;
      analogOperational_q <= 1'b0;
      analogBiasOn_q <= 1'b0;
      dacSoftMute_q <= 1'b0;
      powerOneEnable_q <= {WORD_W{1'b0}};
      powerTwoEnable_q <= {WORD_W{1'b0}};
      powerThreeEnable_q <= {WORD_W{1'b0}};
    end else begin
      dacOversampleDouble_q <= dacDouble;
      adcOversampleDouble_q <= adcDouble;
      dacRateSelect_q <= dacDouble ? `CPC_OSR_HIGH : `CPC_OSR_LOW;
      adcRateSelect_q <= adcDouble ? `CPC_OSR_HIGH : `CPC_OSR_LOW;
      midrailImpedanceSelect_q <= midrailCode;
      midrailReference_q <= midrailOn;
      analogOperational_q <= midrailOn;
      analogBiasOn_q <= powerOne[`CPC_BIT_BIAS];
      dacSoftMute_q <= dacCtrl[`CPC_BIT_SOFT_MUTE];
      // Blocks stay off without a reference; the bias bit passes ungated
      // because software clears it itself before dropping the midrail
      powerOneEnable_q <= powerOne & {WORD_W{midrailOn}};
      powerTwoEnable_q <= powerTwo & {WORD_W{midrailOn}};
      powerThreeEnable_q <= powerThree & {WORD_W{midrailOn}};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event pulses

  // One-cycle strobes; write and soft reset follow the commit edge, frame error the latch rise
  always @(posedge sys_clk) begin
    if (reset) begin
      writeDone_q <= 1'b0;
      softResetDone_q <= 1'b0;
      frameError_q <= 1'b0;
    end else begin
      writeDone_q <= storeWrite;
      softResetDone_q <= softResetHit;
      frameError_q <= (state_q == ST_SHIFT) && latchRise && !frameComplete;
    end
  end

endmodule

// [src/cpc_codec_map.vh]
`ifndef CPC_CODEC_MAP_VH
`define CPC_CODEC_MAP_VH

// Serial control word: address in the top bits, register data in the low bits
`define CPC_ADDR_W 7
`define CPC_WORD_W 9
`define CPC_FRAME_BITS 5'd16
`define CPC_DEPTH 32

// Register addresses
`define CPC_ADDR_SOFT_RESET 7'h00
`define CPC_ADDR_POWER_ONE 7'h01
`define CPC_ADDR_POWER_TWO 7'h02
`define CPC_ADDR_POWER_THREE 7'h03
`define CPC_ADDR_AUDIO_PORT 7'h04
`define CPC_ADDR_COMPANDING 7'h05
`define CPC_ADDR_CLOCK_GEN 7'h06
`define CPC_ADDR_EXTRA 7'h07
`define CPC_ADDR_PIN_OUTPUT 7'h08
`define CPC_ADDR_DAC_CTRL 7'h0a
`define CPC_ADDR_DAC_VOLUME 7'h0b
`define CPC_ADDR_ADC_CTRL 7'h0e
`define CPC_ADDR_ADC_VOLUME 7'h0f
`define CPC_ADDR_LIMITER_ONE 7'h18
`define CPC_ADDR_LIMITER_TWO 7'h19
`define CPC_ADDR_NOTCH_ONE 7'h1b
`define CPC_ADDR_NOTCH_TWO 7'h1c

// Reset values
`define CPC_RST_ZERO 9'h000
`define CPC_RST_AUDIO_PORT 9'h050
`define CPC_RST_CLOCK_GEN 9'h140
`define CPC_RST_DAC_VOLUME 9'h0ff
`define CPC_RST_ADC_CTRL 9'h100
`define CPC_RST_ADC_VOLUME 9'h0ff
`define CPC_RST_LIMITER_ONE 9'h032

// Field positions
`define CPC_BIT_OVERSAMPLE 3
`define CPC_BIT_SOFT_MUTE 6
`define CPC_BIT_BIAS 3
`define CPC_MIDRAIL_HI 1
`define CPC_MIDRAIL_LO 0

// Midrail impedance codes
`define CPC_MIDRAIL_OFF 2'h0
`define CPC_MIDRAIL_50K 2'h1
`define CPC_MIDRAIL_500K 2'h2
`define CPC_MIDRAIL_5K 2'h3

// Oversampling ratios
`define CPC_OSR_LOW 8'h40
`define CPC_OSR_HIGH 8'h80

`endif

// [src/cpc_pin_sync.v]
`timescale 1ns/100ps
`include "cpc_codec_map.vh"

module cpc_pin_sync #(
  parameter WIDTH = 3
) (
  input wire sys_clk, // System clock
  input wire reset, // Synchronous reset, high
  input wire [WIDTH-1:0] pinIn, // Raw pin levels
  input wire [WIDTH-1:0] resetLevel, // Idle level after reset
  output wire [WIDTH-1:0] pinStable // Filtered levels
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : gSync
      reg stage1_q;
      reg stage2_q;
      reg stage3_q;
      reg stable_q;
      // Stage one feeds stage two only; accept a change once two and three agree
      always @(posedge sys_clk) begin
        stage1_q <= pinIn[g];
        stage2_q <= stage1_q;
        stage3_q <= stage2_q;
        if (reset) begin
          stable_q <= resetLevel[g];
        end else if (stage2_q == stage3_q) begin
          stable_q <= stage3_q;
        end
      end
      assign pinStable[g] = stable_q;
    end
  endgenerate

endmodule

// [src/cpc_reg_store.v]
`timescale 1ns/100ps
`include "cpc_codec_map.vh"

module cpc_reg_store #(
  parameter ADDR_W = `CPC_ADDR_W,
  parameter WORD_W = `CPC_WORD_W,
  parameter DEPTH = `CPC_DEPTH
) (
  input wire sys_clk, // System clock
  input wire clear, // Load defaults into every word
  input wire wrEn, // Write one word
  input wire [ADDR_W-1:0] wrAddr, // Write address
  input wire [WORD_W-1:0] wrData, // Whole nine-bit word
  input wire [ADDR_W-1:0] rdAddr, // Read address
  output reg [WORD_W-1:0] rdData_q, // Registered read data
  output wire [DEPTH*WORD_W-1:0] allWords // Every word, flat
);

  function [WORD_W-1:0] defaultWord;
    input integer a;
    begin
      case (a)
        `CPC_ADDR_AUDIO_PORT: defaultWord = `CPC_RST_AUDIO_PORT;
        `CPC_ADDR_CLOCK_GEN: defaultWord = `CPC_RST_CLOCK_GEN;
        `CPC_ADDR_DAC_VOLUME: defaultWord = `CPC_RST_DAC_VOLUME;
        `CPC_ADDR_ADC_CTRL: defaultWord = `CPC_RST_ADC_CTRL;
        `CPC_ADDR_ADC_VOLUME: defaultWord = `CPC_RST_ADC_VOLUME;
        `CPC_ADDR_LIMITER_ONE: defaultWord = `CPC_RST_LIMITER_ONE;
        default: defaultWord = `CPC_RST_ZERO;
      endcase
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : gWord
      reg [WORD_W-1:0] word_q;
      always @(posedge sys_clk) begin
        if (clear) begin
          word_q <= defaultWord(g);
        end else if (wrEn && (wrAddr == g)) begin
          word_q <= wrData;
        end
      end
      assign allWords[g*WORD_W +: WORD_W] = word_q;
    end
  endgenerate

  always @(posedge sys_clk) begin
    if (clear) begin
      rdData_q <= {WORD_W{1'b0}};
    end else if (rdAddr < DEPTH) begin
      rdData_q <= allWords[rdAddr*WORD_W +: WORD_W];
    end else begin
      // Addresses past the store read as zero, never as unknown
      rdData_q <= {WORD_W{1'b0}};
    end
  end

endmodule

// [verification/cpc_codec_power_ctrl_sva.sv]
`timescale 1ns/100ps
`include "cpc_codec_map.vh"

module cpc_codec_power_ctrl_sva #(
  parameter ADDR_W = `CPC_ADDR_W,
  parameter WORD_W = `CPC_WORD_W
) (
  input wire sys_clk, // System clock
  input wire reset, // Synchronous reset, high
  input wire dacOversampleDouble_q, // DAC at 128x
  input wire adcOversampleDouble_q, // ADC at 128x
  input wire [7:0] dacRateSelect_q, // DAC ratio
  input wire [7:0] adcRateSelect_q, // ADC ratio
  input wire [1:0] midrailImpedanceSelect_q, // Midrail code
  input wire midrailReference_q, // Midrail running
  input wire analogOperational_q, // Analogue usable
  input wire analogBiasOn_q, // Bias on
  input wire dacSoftMute_q, // DAC mute
  input wire [WORD_W-1:0] powerOneEnable_q, // Gated word one
  input wire [WORD_W-1:0] powerTwoEnable_q, // Gated word two
  input wire [WORD_W-1:0] powerThreeEnable_q, // Gated word three
  input wire writeDone_q, // Write pulse
  input wire softResetDone_q, // Soft reset pulse
  input wire frameError_q // Bad frame pulse
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////
  sequence sDefaults;
    dacRateSelect_q == `CPC_OSR_LOW && adcRateSelect_q == `CPC_OSR_LOW && midrailImpedanceSelect_q == 2'h0 &&
      !analogBiasOn_q && !dacSoftMute_q && !analogOperational_q && powerOneEnable_q == 9'h000;
  endsequence
  sequence sWriteApplied;
    writeDone_q ##1 !writeDone_q;
  endsequence

  ////////////////////////////////////////////////////////////////////////
  chk_dac_rate: assert property (dacRateSelect_q == (dacOversampleDouble_q ? `CPC_OSR_HIGH : `CPC_OSR_LOW))
    else $error("dac ratio disagrees with oversample bit");
  chk_adc_rate: assert property (adcRateSelect_q == (adcOversampleDouble_q ? `CPC_OSR_HIGH : `CPC_OSR_LOW))
    else $error("adc ratio disagrees with oversample bit");
  chk_midrail_copy: assert property (powerOneEnable_q[1:0] == midrailImpedanceSelect_q)
    else $error("midrail code differs from power word");
  chk_midrail_ref: assert property (midrailReference_q == (midrailImpedanceSelect_q != 2'h0))
    else $error("midrail reference flag wrong");
  chk_analog_gate: assert property (analogOperational_q == (midrailImpedanceSelect_q != 2'h0))
    else $error("analogue operational flag wrong");
  chk_enable_gate: assert property (midrailImpedanceSelect_q == 2'h0 |->
    powerOneEnable_q == 9'h000 && powerTwoEnable_q == 9'h000 && powerThreeEnable_q == 9'h000)
    else $error("power enables not gated by midrail off");
  chk_bias_copy: assert property (midrailImpedanceSelect_q != 2'h0 |-> powerOneEnable_q[3] == analogBiasOn_q)
    else $error("bias output differs from power word");
  chk_reset_defaults: assert property ($fell(reset) |-> sDefaults)
    else $error("outputs not at defaults after reset");
  chk_soft_defaults: assert property (softResetDone_q |=> sDefaults)
    else $error("outputs not at defaults after soft reset");
  chk_outputs_hold: assert property ($changed(dacRateSelect_q) || $changed(midrailImpedanceSelect_q) ||
    $changed(powerOneEnable_q) |-> $past(writeDone_q) || $past(softResetDone_q))
    else $error("control output moved without a write");
  chk_pulse_single: assert property (writeDone_q |-> sWriteApplied)
    else $error("write pulse longer than one cycle");
  chk_pulse_excl: assert property (frameError_q |-> !writeDone_q && !softResetDone_q)
    else $error("bad frame also applied");
endmodule

// [verification/tb_cpc_codec_power_ctrl.sv]
`timescale 1ns/100ps
`include "cpc_codec_map.vh"

module tb_cpc_codec_power_ctrl;
  reg sys_clk = 1'b0;
  reg reset = 1'b1;
  reg ctrlClk = 1'b0;
  reg ctrlData = 1'b0;
  reg ctrlLatch = 1'b1;
  reg [6:0] regReadAddr = 7'h00;
  wire [8:0] regReadData_q;
  wire dacOversampleDouble_q;
  wire adcOversampleDouble_q;
  wire [7:0] dacRateSelect_q;
  wire [7:0] adcRateSelect_q;
  wire [1:0] midrailImpedanceSelect_q;
  wire midrailReference_q;
  wire analogOperational_q;
  wire analogBiasOn_q;
  wire dacSoftMute_q;
  wire [8:0] powerOneEnable_q;
  wire [8:0] powerTwoEnable_q;
  wire [8:0] powerThreeEnable_q;
  wire writeDone_q;
  wire softResetDone_q;
  wire frameError_q;
  integer failures = 0;
  integer testsRun = 0;
  integer cycles = 0;
  integer i;
  reg [8:0] seen;
  reg [8:0] dataWord;

  cpc_codec_power_ctrl cpc_codec_power_ctrl_i (.sys_clk(sys_clk), .reset(reset), .ctrlClk(ctrlClk),
    .ctrlData(ctrlData), .ctrlLatch(ctrlLatch), .regReadAddr(regReadAddr), .regReadData_q(regReadData_q),
    .dacOversampleDouble_q(dacOversampleDouble_q), .adcOversampleDouble_q(adcOversampleDouble_q),
    .dacRateSelect_q(dacRateSelect_q), .adcRateSelect_q(adcRateSelect_q),
    .midrailImpedanceSelect_q(midrailImpedanceSelect_q), .midrailReference_q(midrailReference_q),
    .analogOperational_q(analogOperational_q), .analogBiasOn_q(analogBiasOn_q), .dacSoftMute_q(dacSoftMute_q),
    .powerOneEnable_q(powerOneEnable_q), .powerTwoEnable_q(powerTwoEnable_q),
    .powerThreeEnable_q(powerThreeEnable_q), .writeDone_q(writeDone_q), .softResetDone_q(softResetDone_q),
    .frameError_q(frameError_q));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  // Whole run needs about 4200 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures = failures + 1;
      testDone;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task tick(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask

  task chk(input [8*10:1] name, input [8:0] expv, input [8:0] got);
    begin
      testsRun = testsRun + 1;
      if (got !== expv) begin
        failures = failures + 1;
        $display("mismatch %0s expected %h seen %h", name, expv, got);
      end
    end
  endtask

  // Pin levels held 5 cycles so the filtered view never misses one
  task sendWord(input [6:0] a, input [8:0] d, input integer n);
    reg [15:0] w;
    integer b;
    begin
      w = {a, d};
      seen = 9'h000;
      ctrlLatch <= 1'b0;
      tick(5);
      for (b = 15; b > 15 - n; b = b - 1) begin
        ctrlData <= w[b];
        tick(5);
        ctrlClk <= 1'b1;
        tick(5);
        ctrlClk <= 1'b0;
      end
      tick(5);
      ctrlLatch <= 1'b1;
      repeat (12) begin
        @(posedge sys_clk);
        if (writeDone_q === 1'b1) seen = 9'h001;
        if (softResetDone_q === 1'b1) seen = 9'h002;
        if (frameError_q === 1'b1) seen = 9'h003;
      end
    end
  endtask

  task readChk(input [6:0] a, input [8:0] expv);
    begin
      regReadAddr <= a;
      tick(3);
      chk("readback", expv, regReadData_q);
    end
  endtask

  function [8:0] defVal(input [6:0] a);
    case (a)
      `CPC_ADDR_AUDIO_PORT: defVal = `CPC_RST_AUDIO_PORT;
      `CPC_ADDR_CLOCK_GEN: defVal = `CPC_RST_CLOCK_GEN;
      `CPC_ADDR_DAC_VOLUME: defVal = `CPC_RST_DAC_VOLUME;
      `CPC_ADDR_ADC_CTRL: defVal = `CPC_RST_ADC_CTRL;
      `CPC_ADDR_ADC_VOLUME: defVal = `CPC_RST_ADC_VOLUME;
      `CPC_ADDR_LIMITER_ONE: defVal = `CPC_RST_LIMITER_ONE;
      default: defVal = `CPC_RST_ZERO;
    endcase
  endfunction

  // Unmapped places and the write-only reset place read as zero
  task chkDefaults;
    begin
      for (i = 0; i < 32; i = i + 1) readChk(i[6:0], defVal(i[6:0]));
      chk("dacRate", 9'h040, dacRateSelect_q);
      chk("adcRate", 9'h040, adcRateSelect_q);
      chk("midrail", 9'h000, midrailImpedanceSelect_q);
      chk("bias", 9'h000, analogBiasOn_q);
      chk("mute", 9'h000, dacSoftMute_q);
    end
  endtask

  task testDone;
    begin
      if (failures == 0 && testsRun > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    tick(16);
    reset <= 1'b0;
    tick(2);
    chkDefaults;
    sendWord(`CPC_ADDR_DAC_CTRL, 9'h048, 16);
    chk("pulse", 9'h001, seen);
    chk("dacDouble", 9'h001, dacOversampleDouble_q);
    chk("dacRate", 9'h080, dacRateSelect_q);
    chk("mute", 9'h001, dacSoftMute_q);
    chk("adcRate", 9'h040, adcRateSelect_q);
    readChk(`CPC_ADDR_DAC_CTRL, 9'h048);
    sendWord(`CPC_ADDR_ADC_CTRL, 9'h108, 16);
    chk("adcDouble", 9'h001, adcOversampleDouble_q);
    chk("adcRate", 9'h080, adcRateSelect_q);
    sendWord(`CPC_ADDR_DAC_CTRL, 9'h040, 16);
    chk("dacRate", 9'h040, dacRateSelect_q);
    sendWord(`CPC_ADDR_POWER_TWO, 9'h1ff, 16);
    chk("powerTwo", 9'h000, powerTwoEnable_q);
    readChk(`CPC_ADDR_POWER_TWO, 9'h1ff);
    sendWord(`CPC_ADDR_POWER_THREE, 9'h155, 16);
    chk("powerThree", 9'h000, powerThreeEnable_q);
    for (i = 0; i < 4; i = i + 1) begin
      dataWord = {1'b1, 4'h0, i[0], 1'b0, i[1:0]};
      sendWord(`CPC_ADDR_POWER_ONE, dataWord, 16);
      chk("midrail", {7'h00, i[1:0]}, midrailImpedanceSelect_q);
      chk("midRef", {8'h00, i != 0}, midrailReference_q);
      chk("operate", {8'h00, i != 0}, analogOperational_q);
      chk("bias", {8'h00, i[0]}, analogBiasOn_q);
      chk("powerOne", i != 0 ? dataWord : 9'h000, powerOneEnable_q);
      chk("powerTwo", i != 0 ? 9'h1ff : 9'h000, powerTwoEnable_q);
      chk("powerThree", i != 0 ? 9'h155 : 9'h000, powerThreeEnable_q);
    end
    sendWord(`CPC_ADDR_POWER_ONE, 9'h000, 15);
    chk("pulse", 9'h003, seen);
    chk("midrail", 9'h003, midrailImpedanceSelect_q);
    sendWord(7'h09, 9'h1aa, 16);
    chk("pulse", 9'h000, seen);
    readChk(7'h09, 9'h000);
    // Standby sequence
    sendWord(`CPC_ADDR_DAC_CTRL, 9'h040, 16);
    sendWord(`CPC_ADDR_POWER_ONE, 9'h000, 16);
    sendWord(`CPC_ADDR_POWER_TWO, 9'h000, 16);
    sendWord(`CPC_ADDR_POWER_THREE, 9'h000, 16);
    sendWord(`CPC_ADDR_POWER_ONE, 9'h002, 16);
    chk("midrail", 9'h002, midrailImpedanceSelect_q);
    chk("mute", 9'h001, dacSoftMute_q);
    chk("powerTwo", 9'h000, powerTwoEnable_q);
    chk("powerThree", 9'h000, powerThreeEnable_q);
    chk("powerOne", 9'h002, powerOneEnable_q);
    chk("bias", 9'h000, analogBiasOn_q);
    // Minimum power sequence after reset
    sendWord(`CPC_ADDR_DAC_CTRL, 9'h040, 16);
    sendWord(`CPC_ADDR_POWER_ONE, 9'h000, 16);
    sendWord(`CPC_ADDR_SOFT_RESET, 9'h0ff, 16);
    chk("pulse", 9'h002, seen);
    chkDefaults;
    sendWord(`CPC_ADDR_POWER_ONE, 9'h002, 16);
    chk("midrail", 9'h002, midrailImpedanceSelect_q);
    // Power-on reset in mid-run
    sendWord(`CPC_ADDR_CLOCK_GEN, 9'h1ff, 16);
    readChk(`CPC_ADDR_CLOCK_GEN, 9'h1ff);
    reset <= 1'b1;
    tick(16);
    reset <= 1'b0;
    tick(2);
    chkDefaults;
    testDone;
  end
endmodule

bind cpc_codec_power_ctrl cpc_codec_power_ctrl_sva #(.ADDR_W(ADDR_W), .WORD_W(WORD_W)) cpc_codec_power_ctrl_sva_i (
  .sys_clk(sys_clk), .reset(reset), .dacOversampleDouble_q(dacOversampleDouble_q),
  .adcOversampleDouble_q(adcOversampleDouble_q), .dacRateSelect_q(dacRateSelect_q),
  .adcRateSelect_q(adcRateSelect_q), .midrailImpedanceSelect_q(midrailImpedanceSelect_q),
  .midrailReference_q(midrailReference_q), .analogOperational_q(analogOperational_q),
  .analogBiasOn_q(analogBiasOn_q), .dacSoftMute_q(dacSoftMute_q), .powerOneEnable_q(powerOneEnable_q),
  .powerTwoEnable_q(powerTwoEnable_q), .powerThreeEnable_q(powerThreeEnable_q), .writeDone_q(writeDone_q),
  .softResetDone_q(softResetDone_q), .frameError_q(frameError_q));
